/* prbs_receive_checker.sv */
// What this block does
// RQ1: the checker hunts for a 2^15-1 pattern with the standard bit low or hardware reset low, 2^20-1 when the bit is high.
// RQ2: the error output stays high while the checker is not in sync.
// RQ3: once in sync the error output goes low.
// RQ4: in sync, each wrong bit gives a one-clock high pulse on the error output.
// RQ5: with counting enabled, each detected bit error also increments both error counts.
// RQ6: hardware reset low clears the standard select and count enable bits.
// RQ7: the checker runs on the recovered receive clock.
// RQ8: patterns use 15- and 20-stage shift registers, seeded from data, locked after an error-free run; the code uses one 20-stage register for both.
//
// Purpose: receive pseudo-random pattern checker with lock and bit-error reporting
// Assumes: rx_data is sampled on ref_clk, which carries the recovered receive clock
// Notes: control bits arrive as pins, held in flops cleared by hardware_reset_n
`timescale 1ns/100ps
module prbs_receive_checker #(
	parameter int CNT_W = prbs_pkg::COUNT_W
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic hardware_reset_n,
	input wire logic rx_data,
	input wire logic line_standard_bit,
	input wire logic pattern_error_count_enable,
	output logic pattern_error_out,
	output logic in_sync,
	output logic [CNT_W-1:0] error_count_reg_a,
	output logic [CNT_W-1:0] error_count_reg_b
);
	import prbs_pkg::*;

	// ------------------------------------------------------------
	// control bits
	// ------------------------------------------------------------
	logic hardware_reset_n_n_s;
	logic std_s;
	logic cnt_en_s;
	logic ctl_clr;
	logic line_standard_select_r;
	logic line_standard_select_nxt;
	logic cnt_en_r;
	logic cnt_en_nxt;

	bit_sync #(.RST_VAL(1'b1)) u_sync_hardware_reset_n (
		.clk(ref_clk),
		.rst(reset),
		.din(hardware_reset_n),
		.dout(hardware_reset_n_n_s)
	);
	bit_sync #(.RST_VAL(RST_STD)) u_sync_std (
		.clk(ref_clk),
		.rst(reset),
		.din(line_standard_bit),
		.dout(std_s)
	);
	bit_sync #(.RST_VAL(RST_CNT_EN)) u_sync_cnt (
		.clk(ref_clk),
		.rst(reset),
		.din(pattern_error_count_enable),
		.dout(cnt_en_s)
	);

	assign ctl_clr = reset || !hardware_reset_n_n_s;

	always_comb begin
		line_standard_select_nxt = std_s;
		cnt_en_nxt = cnt_en_s;
		if (ctl_clr) begin
			line_standard_select_nxt = RST_STD; // RQ6
			cnt_en_nxt = RST_CNT_EN; // RQ6
		end
	end

	always_ff @(posedge ref_clk) begin
		line_standard_select_r <= line_standard_select_nxt;
		cnt_en_r <= cnt_en_nxt;
	end

	// ------------------------------------------------------------
	// pattern prediction
	// ------------------------------------------------------------
	logic [LEN_LONG-1:0] lfsr_r;
	logic [LEN_LONG-1:0] lfsr_nxt;
	logic rx_r;
	logic std_prev_r;
	logic expect_bit;
	logic bit_err;

	// the data bit is registered once: same domain, no synchroniser needed
	always_ff @(posedge ref_clk) begin // RQ7
		rx_r <= reset ? 1'b0 : rx_data;
		std_prev_r <= reset ? RST_STD : line_standard_select_r;
	end

	always_comb begin
		if (line_standard_select_r) begin // RQ1
			expect_bit = lfsr_r[TAP_LONG_A-1] ^ lfsr_r[TAP_LONG_B-1]; // RQ8
		end else begin
			expect_bit = lfsr_r[TAP_SHORT_A-1] ^ lfsr_r[TAP_SHORT_B-1]; // RQ8
		end
		bit_err = expect_bit ^ rx_r;
	end

	// ------------------------------------------------------------
	// sync state machine
	// ------------------------------------------------------------
	sync_state_e state_r;
	sync_state_e state_nxt;
	logic [5:0] run_r;
	logic [5:0] run_nxt;
	logic [6:0] win_r;
	logic [6:0] win_nxt;
	logic [2:0] errs_r;
	logic [2:0] errs_nxt;
	logic err_pulse_r;
	logic err_pulse_nxt;

	always_comb begin
		state_nxt = state_r;
		run_nxt = run_r;
		win_nxt = win_r;
		errs_nxt = errs_r;
		err_pulse_nxt = 1'b0;
		// seeding: shift received data in, a self-synchronising load
		lfsr_nxt = {lfsr_r[LEN_LONG-2:0], rx_r};
		case (state_r)
			ST_SEED: begin
				if (run_r == 6'(LEN_LONG - 1)) begin
					state_nxt = ST_VERIFY;
					run_nxt = 6'h00;
				end else begin
					run_nxt = run_r + 6'h01;
				end
			end
			ST_VERIFY: begin
				if (bit_err) begin
					state_nxt = ST_SEED;
					run_nxt = 6'h00;
				end else if (run_r == 6'(LOCK_RUN - 1)) begin
					state_nxt = ST_LOCKED; // RQ8
					win_nxt = 7'h00;
					errs_nxt = 3'h0;
				end else begin
					run_nxt = run_r + 6'h01;
				end
			end
			ST_LOCKED: begin
				// free-run on predicted bits so errors do not propagate
				lfsr_nxt = {lfsr_r[LEN_LONG-2:0], expect_bit};
				err_pulse_nxt = bit_err; // RQ4
				win_nxt = win_r + 7'h01;
				if (bit_err) begin
					errs_nxt = errs_r + 3'h1;
				end
				if (bit_err && errs_r == 3'(LOSE_ERRS - 1)) begin
					state_nxt = ST_SEED;
					run_nxt = 6'h00;
				end else if (win_r == 7'(LOSE_WINDOW - 1)) begin
					win_nxt = 7'h00;
					errs_nxt = 3'h0;
				end
			end
			default: begin
				state_nxt = ST_SEED;
				run_nxt = 6'h00;
			end
		endcase
		// a change of pattern restarts the hunt
		if (line_standard_select_r != std_prev_r) begin // RQ1
			state_nxt = ST_SEED;
			run_nxt = 6'h00;
			err_pulse_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r <= ST_SEED;
			lfsr_r <= '0;
			run_r <= 6'h00;
			win_r <= 7'h00;
			errs_r <= 3'h0;
			err_pulse_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			lfsr_r <= lfsr_nxt;
			run_r <= run_nxt;
			win_r <= win_nxt;
			errs_r <= errs_nxt;
			err_pulse_r <= err_pulse_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs and counters
	// ------------------------------------------------------------
	logic out_r;
	logic out_nxt;
	logic [CNT_W-1:0] cnt_a_r;
	logic [CNT_W-1:0] cnt_a_nxt;
	logic [CNT_W-1:0] cnt_b_r;
	logic [CNT_W-1:0] cnt_b_nxt;

	always_comb begin
		// high out of sync, low in sync, pulses on errors
		out_nxt = (state_nxt != ST_LOCKED) || err_pulse_nxt; // RQ2 RQ3 RQ4
		cnt_a_nxt = cnt_a_r;
		cnt_b_nxt = cnt_b_r;
		// counters saturate rather than wrap to stay meaningful
		if (cnt_en_r && err_pulse_nxt) begin // RQ5
			if (cnt_a_r != '1) begin
				cnt_a_nxt = cnt_a_r + CNT_W'(1);
			end
			if (cnt_b_r != '1) begin
				cnt_b_nxt = cnt_b_r + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			out_r <= 1'b1;
			cnt_a_r <= '0;
			cnt_b_r <= '0;
		end else begin
			out_r <= out_nxt;
			cnt_a_r <= cnt_a_nxt;
			cnt_b_r <= cnt_b_nxt;
		end
	end

	assign pattern_error_out = out_r;
	assign in_sync = (state_r == ST_LOCKED);
	assign error_count_reg_a = cnt_a_r;
	assign error_count_reg_b = cnt_b_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_out_unsync: assert property (@(posedge ref_clk) disable iff (reset) // RQ2
		!in_sync |-> pattern_error_out)
		else $error("error output low while out of sync");
	chk_out_sync: assert property (@(posedge ref_clk) disable iff (reset) // RQ3
		in_sync && !err_pulse_r |-> !pattern_error_out)
		else $error("error output high while in sync without error");
	chk_err_pulse: assert property (@(posedge ref_clk) disable iff (reset) // RQ4
		state_r == ST_LOCKED && state_nxt == ST_LOCKED && bit_err
		&& line_standard_select_r == std_prev_r |=> pattern_error_out)
		else $error("missed error pulse");
	chk_count_step: assert property (@(posedge ref_clk) disable iff (reset) // RQ5
		cnt_en_r && err_pulse_nxt && cnt_a_r != '1 |=> cnt_a_r == $past(cnt_a_r) + CNT_W'(1))
		else $error("error count did not step");
	chk_count_hold: assert property (@(posedge ref_clk) disable iff (reset) // RQ5
		!cnt_en_r |=> $stable(cnt_a_r) && $stable(cnt_b_r))
		else $error("error count moved while disabled");
	chk_ctl_clear: assert property (@(posedge ref_clk) disable iff (reset) // RQ6
		!hardware_reset_n_n_s |=> !line_standard_select_r && !cnt_en_r)
		else $error("control bits not cleared by hardware reset");
	chk_lock_run: assert property (@(posedge ref_clk) disable iff (reset) // RQ8
		$rose(in_sync) |-> $past(state_r) == ST_VERIFY)
		else $error("lock without verify run");
	chk_std_restart: assert property (@(posedge ref_clk) disable iff (reset) // RQ1
		line_standard_select_r != std_prev_r |=> state_r == ST_SEED)
		else $error("pattern change did not restart hunt");

	cov_lock: cover property (@(posedge ref_clk) disable iff (reset) $rose(in_sync));
	cov_err: cover property (@(posedge ref_clk) disable iff (reset) in_sync && err_pulse_r);
	cov_lose: cover property (@(posedge ref_clk) disable iff (reset) $fell(in_sync));

endmodule : prbs_receive_checker

/* prbs_pkg.sv */
// Purpose: shared constants for the receive pattern checker
// Assumes: one clock domain (recovered receive clock)
// Notes: tap positions are the usual maximal-length taps
package prbs_pkg;

	localparam int LEN_SHORT = 15;
	localparam int LEN_LONG = 20;
	// feedback taps, one-based stage numbers
	localparam int TAP_SHORT_A = 15;
	localparam int TAP_SHORT_B = 14;
	localparam int TAP_LONG_A = 20;
	localparam int TAP_LONG_B = 17;
	localparam int LOCK_RUN = 32;
	localparam int LOSE_ERRS = 6;
	localparam int LOSE_WINDOW = 64;
	localparam int COUNT_W = 16;
	localparam logic RST_STD = 1'b0;
	localparam logic RST_CNT_EN = 1'b0;

	typedef enum logic [1:0] {
		ST_SEED = 2'b00,
		ST_VERIFY = 2'b01,
		ST_LOCKED = 2'b10
	} sync_state_e;

endpackage : prbs_pkg

/* bit_sync.sv */
// Purpose: two-stage synchroniser for a level from outside the clock domain
// Assumes: input is a quasi-static level
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module bit_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);

	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;

	always_comb begin
		meta_nxt = din;
		sync_nxt = meta_r;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign dout = sync_r;

endmodule : bit_sync

/* prbs_line_source.sv */
// Purpose: far-end test set sending a pattern over the line
// Assumes: a new bit is launched on each falling edge of the line clock
// Notes: inject flips only the current bit and leaves the generator state alone
`timescale 1ns/100ps
module prbs_line_source (
	input wire logic clk,
	input wire logic long_sel,
	input wire logic inject,
	output logic data
);
	logic [19:0] gen_r = 20'hFFFFF;
	logic fb;

	// bit 0 is the newest bit sent
	assign fb = long_sel ? (gen_r[19] ^ gen_r[16]) : (gen_r[14] ^ gen_r[13]);
	always @(negedge clk) begin
		gen_r <= {gen_r[18:0], fb};
	end
	assign data = gen_r[0] ^ inject;
endmodule : prbs_line_source

/* prbs_receive_checker_tb.sv */
// Purpose: self-checking bench for the receive pattern checker
// Assumes: 100 ns clock, inputs driven on falling edges
// Notes: a single bad bit must never cost lock, so losses are forced by pattern change
`timescale 1ns/100ps
module prbs_receive_checker_tb;
	import prbs_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic hardware_reset_n = 1'b1;
	logic line_standard_bit = 1'b0;
	logic pattern_error_count_enable = 1'b0;
	logic long_sel = 1'b0;
	logic inject = 1'b0;
	logic rx_data;
	logic pattern_error_out;
	logic in_sync;
	logic [COUNT_W-1:0] error_count_reg_a;
	logic [COUNT_W-1:0] error_count_reg_b;
	int fails = 0;
	int checks_done = 0;

	prbs_line_source far_end (.clk(ref_clk), .long_sel(long_sel), .inject(inject), .data(rx_data));
	prbs_receive_checker dut (.ref_clk(ref_clk), .reset(reset),
		.hardware_reset_n(hardware_reset_n), .rx_data(rx_data),
		.line_standard_bit(line_standard_bit),
		.pattern_error_count_enable(pattern_error_count_enable),
		.pattern_error_out(pattern_error_out), .in_sync(in_sync),
		.error_count_reg_a(error_count_reg_a), .error_count_reg_b(error_count_reg_b));

	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// waits up to 200 bits for the lock level, then checks it and the output pin
	task automatic wait_sync(input logic want);
		int n;
		n = 0;
		while (in_sync !== want && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		repeat (2) @(negedge ref_clk);
		check({15'h0, in_sync}, {15'h0, want});
		check({15'h0, pattern_error_out}, {15'h0, ~want});
	endtask : wait_sync

	// one bad bit; counts the high cycles of the error pin afterwards
	task automatic hit(input logic cnt_on);
		logic [15:0] a0;
		logic [15:0] b0;
		int highs;
		a0 = error_count_reg_a;
		b0 = error_count_reg_b;
		highs = 0;
		inject <= 1'b1;
		@(negedge ref_clk);
		inject <= 1'b0;
		repeat (6) begin
			@(negedge ref_clk);
			if (pattern_error_out === 1'b1) highs++;
		end
		check(16'(highs), 16'h0001);
		check(error_count_reg_a, cnt_on ? a0 + 16'h0001 : a0);
		check(error_count_reg_b, cnt_on ? b0 + 16'h0001 : b0);
		check({15'h0, in_sync}, 16'h0001);
	endtask : hit

	task automatic test_short_lock;
		check({15'h0, pattern_error_out}, 16'h0001);
		wait_sync(1'b1);
		$display("test short_lock done");
	endtask : test_short_lock

	task automatic test_errors;
		pattern_error_count_enable <= 1'b1;
		repeat (4) @(negedge ref_clk);
		hit(1'b1);
		hit(1'b1);
		pattern_error_count_enable <= 1'b0;
		repeat (4) @(negedge ref_clk);
		hit(1'b0);
		$display("test errors done");
	endtask : test_errors

	task automatic test_long_lock;
		long_sel <= 1'b1;
		wait_sync(1'b0);
		line_standard_bit <= 1'b1;
		wait_sync(1'b1);
		$display("test long_lock done");
	endtask : test_long_lock

	// control flops cleared: checker falls back to the short pattern and stops counting
	task automatic test_hw_reset;
		pattern_error_count_enable <= 1'b1;
		hardware_reset_n <= 1'b0;
		wait_sync(1'b0);
		long_sel <= 1'b0;
		wait_sync(1'b1);
		hit(1'b0);
		// release: select follows its pin again, so short lock is lost before long relock
		hardware_reset_n <= 1'b1;
		long_sel <= 1'b1;
		wait_sync(1'b0);
		wait_sync(1'b1);
		$display("test hw_reset done");
	endtask : test_hw_reset

	initial begin
		repeat (16) @(negedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		test_short_lock();
		test_errors();
		test_long_lock();
		test_hw_reset();
		give_verdict();
	end

	// whole run is about 300 bits; twenty times that is a hang
	initial begin
		#600000;
		fails++;
		give_verdict();
	end
endmodule : prbs_receive_checker_tb
